// ==== logic/flas_pkg.sv ====
// Purpose: Shared constants for the fun-light audio sync and pin test block.
// Assumes: 100 MHz clock, byte-wide register port with 8-bit addresses.
// Notes:   Offsets, field positions, reset values and timing counts live here.
`default_nettype none
package flas_pkg;
   // Register offsets.
   localparam logic [7:0] OFF_CURRENT   = 8'h0c;
   localparam logic [7:0] OFF_AUDIO     = 8'h0d;
   localparam logic [7:0] OFF_THRESHOLD = 8'h0e;
   localparam logic [7:0] OFF_TEST_SEL  = 8'h12;
   localparam logic [7:0] OFF_TEST_RES  = 8'h13;
   // Audio control field positions.
   localparam int GAIN_MSB      = 7;
   localparam int GAIN_LSB      = 5;
   localparam int HIGHPASS_BIT  = 4;
   localparam int AUTO_GAIN_BIT = 3;
   localparam int FOLLOW_BIT    = 2;
   localparam int RATE_MSB      = 1;
   localparam int RATE_LSB      = 0;
   // Threshold and test select field positions.
   localparam int THRESH_MSB    = 3;
   localparam int THRESH_LSB    = 0;
   localparam int MEASURE_BIT   = 4;
   localparam int SOURCE_MSB    = 3;
   localparam int SOURCE_LSB    = 0;
   // Reset values.
   localparam logic [7:0] RST_CURRENT   = 8'h00;
   localparam logic [7:0] RST_AUDIO     = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic [7:0] RST_TEST_SEL  = 8'h00;
   localparam logic [7:0] RST_TEST_RES  = 8'h00;
   // Writable bit masks; unused bits read as zero.
   localparam logic [7:0] MASK_THRESHOLD = 8'h0f;
   localparam logic [7:0] MASK_TEST_SEL  = 8'h1f;
   // Test source codes.
   localparam logic [3:0] SRC_LAST_RGB = 4'hb;
   localparam logic [3:0] SRC_FUN      = 4'hc;
   localparam logic [3:0] SRC_BOOST    = 4'hf;
   // Timing.
   localparam int CLK_MHZ         = 100;
   localparam int CONV_PERIOD_US  = 128;
   localparam int CONV_CYCLES     = CONV_PERIOD_US * CLK_MHZ;
   localparam int REFRESH_FAST_US = 100;
   localparam int REFRESH_15_US   = 66667;
   localparam int REFRESH_7_US    = 131579;
   localparam int REFRESH_3_US    = 263158;
   // Test mux state.
   typedef enum logic [1:0]
   {
      FLAS_IDLE = 2'b01,
      FLAS_CONV = 2'b10
   } flas_test_state_t;
endpackage
`default_nettype wire

// ==== logic/flas_tick.sv ====
// Purpose: Free running divider giving a one-cycle enable every i_period cycles, or every PERIOD cycles when i_period is zero.
// Assumes: Single clock, synchronous active-high reset; i_restart realigns.
// Notes:   Used for the conversion period and the refresh period.
`timescale 1ns/1ns
`default_nettype none
module flas_tick
#(
   parameter int PERIOD = 12800
)
(
   input  wire logic        i_clk,      // System clock.
   input  wire logic        i_reset,    // Synchronous reset, active high.
   input  wire logic        i_restart,  // Restart count from zero.
   input  wire logic [24:0] i_period,   // Period in cycles, zero uses PERIOD.
   output logic             o_tick      // One-cycle pulse at end of period.
);
   logic [24:0] count_reg;
   logic [24:0] count_next;
   logic [24:0] limit;

   // Next count and tick decision.
   always_comb
   begin
      limit      = (i_period == 25'h0) ? 25'(PERIOD - 1) : i_period - 25'h1;
      o_tick     = !i_restart && (count_reg >= limit);
      count_next = (i_restart || o_tick) ? 25'h0 : count_reg + 25'h1;
   end

   // Count register.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         count_reg <= 25'h0;
      else
         count_reg <= count_next;
   end
endmodule
`default_nettype wire

// ==== logic/flas_top.sv ====
// Purpose: Register file and control for the fun-light sink, audio follow and pin test.
// Assumes: Registers reached over a byte-wide port decoded from the serial interface.
// Notes:   Analog parts sit outside; this drives their control codes.
`timescale 1ns/1ns
`default_nettype none
module flas_top
(
   input  wire logic       i_clk,            // System clock, 100 MHz.
   input  wire logic       i_reset,          // Synchronous reset, active high.
   input  wire logic [7:0] i_addr,           // Register address.
   input  wire logic       i_wr,             // Write strobe, one cycle.
   input  wire logic [7:0] i_wdata,          // Write data.
   output logic      [7:0] o_rdata,          // Read data for i_addr, combinational.
   input  wire logic [7:0] i_adc_code,       // Converter code, 27.345 mV per step.
   output logic            o_adc_start,      // Conversion start pulse.
   output logic            o_test_connect,   // Divider connected to a source.
   output logic      [3:0] o_test_source,    // Routed source code.
   output logic            o_sink_enable,    // Fun-light sink active.
   output logic      [7:0] o_sink_code,      // Current code, 15 mA / 255 per step.
   output logic      [7:0] o_level_in,       // Peak level from audio path.
   input  wire logic [7:0] i_audio_level,    // Audio peak level input.
   output logic            o_refresh,        // Brightness refresh pulse.
   output logic      [2:0] o_manual_gain,    // Manual attenuation code.
   output logic            o_auto_gain,      // Automatic gain active.
   output logic            o_highpass_high,  // High-pass corner at 510 Hz.
   output logic      [3:0] o_threshold       // Noise threshold code, 0 off.
);
   logic [7:0] current_reg;
   logic [7:0] current_next;
   logic [7:0] audio_reg;
   logic [7:0] audio_next;
   logic [7:0] threshold_reg;
   logic [7:0] threshold_next;
   logic [7:0] test_sel_reg;
   logic [7:0] test_sel_next;
   logic [7:0] test_res_reg;
   logic [7:0] test_res_next;
   logic [7:0] level_reg;
   logic [7:0] level_next;
   logic       start_reg;
   logic       start_next;
   logic       conv_tick;
   logic       refresh_tick;
   logic       following;
   logic       measuring;
   logic [24:0] refresh_period;
   flas_pkg::flas_test_state_t state_reg;
   flas_pkg::flas_test_state_t state_next;

   // Converts a refresh time in microseconds to clock cycles.
   function automatic logic [24:0] us_to_cycles(input int us);
      us_to_cycles = 25'(us * flas_pkg::CLK_MHZ);
   endfunction

   assign following = audio_reg[flas_pkg::FOLLOW_BIT];
   assign measuring = test_sel_reg[flas_pkg::MEASURE_BIT];

   // Register writes; the result register has no write path.
   always_comb
   begin
      current_next   = current_reg;
      audio_next     = audio_reg;
      threshold_next = threshold_reg;
      test_sel_next  = test_sel_reg;
      if (i_wr)
      begin
         unique case (i_addr)
            flas_pkg::OFF_CURRENT:   current_next   = i_wdata;
            flas_pkg::OFF_AUDIO:     audio_next     = i_wdata;
            flas_pkg::OFF_THRESHOLD: threshold_next = i_wdata & flas_pkg::MASK_THRESHOLD;
            flas_pkg::OFF_TEST_SEL:  test_sel_next  = i_wdata & flas_pkg::MASK_TEST_SEL;
            default:                 current_next   = current_reg;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         current_reg   <= flas_pkg::RST_CURRENT;
         audio_reg     <= flas_pkg::RST_AUDIO;
         threshold_reg <= flas_pkg::RST_THRESHOLD;
         test_sel_reg  <= flas_pkg::RST_TEST_SEL;
      end
      else
      begin
         current_reg   <= current_next;
         audio_reg     <= audio_next;
         threshold_reg <= threshold_next;
         test_sel_reg  <= test_sel_next;
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb
   begin
      unique case (i_addr)
         flas_pkg::OFF_CURRENT:   o_rdata = current_reg;
         flas_pkg::OFF_AUDIO:     o_rdata = audio_reg;
         flas_pkg::OFF_THRESHOLD: o_rdata = threshold_reg;
         flas_pkg::OFF_TEST_SEL:  o_rdata = test_sel_reg;
         flas_pkg::OFF_TEST_RES:  o_rdata = test_res_reg;
         default:                 o_rdata = 8'h00;
      endcase
   end

   // Conversion period timer, realigned while measurement is off.
   flas_tick #(.PERIOD(flas_pkg::CONV_CYCLES)) u_conv_tick
   (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_restart (!measuring),
      .i_period  (25'h0),
      .o_tick    (conv_tick)
   );

   // Test sequencer: a conversion starts as soon as measurement is enabled and
   // again at each 128 us tick; each tick latches the code that the last start gave.
   always_comb
   begin
      state_next    = state_reg;
      test_res_next = test_res_reg;
      start_next    = 1'b0;
      unique case (state_reg)
         flas_pkg::FLAS_IDLE:
         begin
            if (measuring)
            begin
               state_next = flas_pkg::FLAS_CONV;
               start_next = 1'b1;
            end
         end
         flas_pkg::FLAS_CONV:
         begin
            if (!measuring)
               state_next = flas_pkg::FLAS_IDLE;
            else if (conv_tick)
            begin
               start_next    = 1'b1;
               test_res_next = i_adc_code;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg    <= flas_pkg::FLAS_IDLE;
         test_res_reg <= flas_pkg::RST_TEST_RES;
         start_reg    <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         test_res_reg <= test_res_next;
         start_reg    <= start_next;
      end
   end

   assign o_adc_start    = start_reg;
   assign o_test_connect = measuring
                           && (test_sel_reg[flas_pkg::SOURCE_MSB:flas_pkg::SOURCE_LSB]
                               <= flas_pkg::SRC_FUN
                               || test_sel_reg[flas_pkg::SOURCE_MSB:flas_pkg::SOURCE_LSB]
                               == flas_pkg::SRC_BOOST);
   assign o_test_source  = test_sel_reg[flas_pkg::SOURCE_MSB:flas_pkg::SOURCE_LSB];

   // Refresh period selected by the rate code.
   always_comb
   begin
      unique case (audio_reg[flas_pkg::RATE_MSB:flas_pkg::RATE_LSB])
         2'b00:   refresh_period = us_to_cycles(flas_pkg::REFRESH_FAST_US);
         2'b01:   refresh_period = us_to_cycles(flas_pkg::REFRESH_15_US);
         2'b10:   refresh_period = us_to_cycles(flas_pkg::REFRESH_7_US);
         default: refresh_period = us_to_cycles(flas_pkg::REFRESH_3_US);
      endcase
   end

   flas_tick #(.PERIOD(flas_pkg::CONV_CYCLES)) u_refresh_tick
   (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_restart (!following),
      .i_period  (refresh_period),
      .o_tick    (refresh_tick)
   );

   // Level follows audio peak at each refresh while following.
   always_comb
   begin
      level_next = level_reg;
      if (!following)
         level_next = 8'h00;
      else if (refresh_tick)
         level_next = i_audio_level;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         level_reg <= 8'h00;
      else
         level_reg <= level_next;
   end

   assign o_refresh     = refresh_tick;
   assign o_level_in    = level_reg;
   // Sink code: host code in direct mode, audio level while following.
   assign o_sink_code   = following ? level_reg : current_reg;
   assign o_sink_enable = following || (current_reg != 8'h00);
   assign o_manual_gain = audio_reg[flas_pkg::GAIN_MSB:flas_pkg::GAIN_LSB];
   assign o_auto_gain   = audio_reg[flas_pkg::AUTO_GAIN_BIT];
   assign o_highpass_high = audio_reg[flas_pkg::HIGHPASS_BIT];
   assign o_threshold   = threshold_reg[flas_pkg::THRESH_MSB:flas_pkg::THRESH_LSB];
endmodule
`default_nettype wire

// ==== test/flas_top_sva.sv ====
// Purpose: Port-level assertions for flas_top.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached by the bind below the module.
`timescale 1ns/1ns
`default_nettype none
module flas_top_sva
(
   input wire logic       i_clk,           // Clock.
   input wire logic       i_reset,         // Reset.
   input wire logic [7:0] i_addr,          // Address.
   input wire logic       i_wr,            // Write strobe.
   input wire logic [7:0] i_wdata,         // Write data.
   input wire logic       o_adc_start,     // Start pulse.
   input wire logic       o_test_connect,  // Divider connected.
   input wire logic [3:0] o_test_source,   // Routed source.
   input wire logic       o_sink_enable,   // Sink on.
   input wire logic [2:0] o_manual_gain,   // Gain code.
   input wire logic       o_highpass_high, // Corner select.
   input wire logic [3:0] o_threshold      // Threshold code.
);
   // All checks share the clock and reset.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   logic meas_seen;

   // Mirrors the measure enable bit from the bus writes.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         meas_seen <= 1'b0;
      else if (i_wr && i_addr == 8'h12)
         meas_seen <= i_wdata[4];
   end

   property p_gain; (i_wr && i_addr == 8'h0d) |=> o_manual_gain == $past(i_wdata[7:5]); endproperty
   a_gain: assert property (p_gain) else $error("gain code not taken");
   property p_hp; (i_wr && i_addr == 8'h0d) |=> o_highpass_high == $past(i_wdata[4]); endproperty
   a_hp: assert property (p_hp) else $error("corner select not taken");
   property p_thr; (i_wr && i_addr == 8'h0e) |=> o_threshold == $past(i_wdata[3:0]); endproperty
   a_thr: assert property (p_thr) else $error("threshold not taken");
   property p_src; (i_wr && i_addr == 8'h12) |=> o_test_source == $past(i_wdata[3:0]); endproperty
   a_src: assert property (p_src) else $error("source not taken");
   property p_sink; (i_wr && i_addr == 8'h0c && i_wdata != 8'h00) |=> o_sink_enable; endproperty
   a_sink: assert property (p_sink) else $error("sink stayed off");
   property p_first;
      (i_wr && i_addr == 8'h12 && i_wdata[4] && !meas_seen)
         |-> ##2 o_adc_start ##1 !o_adc_start [*8];
   endproperty
   a_first: assert property (p_first) else $error("no start after enable");
   property p_gap; o_adc_start |=> !o_adc_start [*8]; endproperty
   a_gap: assert property (p_gap) else $error("starts too close");
   property p_none;
      (o_test_source == 4'hd || o_test_source == 4'he) |-> !o_test_connect;
   endproperty
   a_none: assert property (p_none) else $error("unused code connected");

   // Main scenarios seen at least once.
   c_start: cover property (o_adc_start);
   c_conn: cover property (o_test_connect);
   c_sink: cover property (o_sink_enable);
endmodule
bind flas_top flas_top_sva i_sva (.i_clk, .i_reset, .i_addr, .i_wr, .i_wdata, .o_adc_start,
   .o_test_connect, .o_test_source, .o_sink_enable, .o_manual_gain, .o_highpass_high,
   .o_threshold);
`default_nettype wire

// ==== test/flas_adc_model.sv ====
// Purpose: Converter model feeding flas_top.
// Assumes: A new code lands on each start pulse.
// Notes:   Codes step by 13h so each result differs.
`timescale 1ns/1ns
`default_nettype none
module flas_adc_model
(
   input  wire logic       i_clk,   // Clock.
   input  wire logic       i_reset, // Reset.
   input  wire logic       i_start, // Start pulse.
   output logic      [7:0] o_code   // Latest code.
);
   // Pins are held at full duty, so codes move only per conversion.
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_code <= 8'h40;
      else if (i_start)
         o_code <= o_code + 8'h13;
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for flas_top.
// Assumes: Inputs change on the falling edge.
// Notes:   Register rows first, then field, sink and measurement cases.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic       i_clk = 1'b0;
   logic       i_reset = 1'b1;
   logic       i_wr = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] i_audio_level = 8'h3c;
   logic [7:0] o_rdata, i_adc_code, o_sink_code, o_level_in, d;
   logic       o_refresh;
   logic [3:0] o_test_source, o_threshold;
   logic [2:0] o_manual_gain;
   logic       o_adc_start, o_test_connect, o_sink_enable, o_auto_gain, o_highpass_high;
   int         n_fail = 0;
   int         n_tests = 0;
   int         n;
   // Rows: address, write data, read back.
   logic [23:0] rows [6] = '{24'h0ca5a5, 24'h0eff0f, 24'h12ef0f, 24'h135500, 24'h207700,
                             24'h0dfbfb};

   always #5 i_clk = ~i_clk;

   flas_top i_dut (.i_clk, .i_reset, .i_addr, .i_wr, .i_wdata, .o_rdata, .i_adc_code,
      .o_adc_start, .o_test_connect, .o_test_source, .o_sink_enable, .o_sink_code,
      .o_level_in, .i_audio_level, .o_refresh, .o_manual_gain, .o_auto_gain,
      .o_highpass_high, .o_threshold);
   flas_adc_model i_adc (.i_clk, .i_reset, .i_start(o_adc_start), .o_code(i_adc_code));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge i_clk);
      i_addr = a;
      i_wdata = v;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      i_addr = a;
      #1 d = o_rdata;
   endtask
   // Counts falling edges until the chosen pulse shows; a lost pulse ends the run.
   task automatic wait_pulse(input bit on_refresh);
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end while ((on_refresh ? o_refresh : o_adc_start) !== 1'b1 && n < 20000);
      if ((on_refresh ? o_refresh : o_adc_start) !== 1'b1)
      begin
         n_fail++;
         final_report();
      end
   endtask

   initial
   begin
      repeat (5) @(negedge i_clk);
      i_reset = 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         rd(rows[k][23:16]);
         chk(d, 8'h00);
      end
      for (int k = 0; k < 6; k++)
      begin
         wr(rows[k][23:16], rows[k][15:8]);
         rd(rows[k][23:16]);
         chk(d, rows[k][7:0]);
      end
      for (int g = 0; g < 8; g++)
      begin
         wr(flas_pkg::OFF_AUDIO, {g[2:0], g[0], g[1], 3'b000});
         wr(flas_pkg::OFF_THRESHOLD, 8'hf0 | 8'(2 * g + 1));
         chk({5'h00, o_manual_gain}, {5'h00, g[2:0]});
         chk({7'h00, o_highpass_high}, {7'h00, g[0]});
         chk({7'h00, o_auto_gain}, {7'h00, g[1]});
         chk({4'h0, o_threshold}, 8'(2 * g + 1));
      end
      for (int s = 0; s < 16; s++)
      begin
         wr(flas_pkg::OFF_TEST_SEL, 8'h10 | 8'(s));
         chk({4'h0, o_test_source}, 8'(s));
         chk({7'h00, o_test_connect}, {7'h00, s < 13 || s == 15});
      end
      // Measurement off: a valid source is not connected.
      wr(flas_pkg::OFF_TEST_SEL, 8'h0c);
      chk({7'h00, o_test_connect}, 8'h00);
      wr(flas_pkg::OFF_AUDIO, 8'h00);
      wr(flas_pkg::OFF_CURRENT, 8'h00);
      chk({7'h00, o_sink_enable}, 8'h00);
      wr(flas_pkg::OFF_CURRENT, 8'hff);
      chk({7'h00, o_sink_enable}, 8'h01);
      chk(o_sink_code, 8'hff);
      wr(flas_pkg::OFF_AUDIO, 8'h04);
      wr(flas_pkg::OFF_CURRENT, 8'h00);
      chk({7'h00, o_sink_enable}, 8'h01);
      wr(flas_pkg::OFF_CURRENT, 8'h11);
      chk({7'h00, o_sink_code == 8'h11}, 8'h00);
      // Fastest refresh; five falling edges went to the writes since follow began.
      wait_pulse(1'b1);
      chk({7'h00, n == flas_pkg::REFRESH_FAST_US * flas_pkg::CLK_MHZ - 5}, 8'h01);
      @(negedge i_clk);
      chk(o_level_in, 8'h3c);
      chk(o_sink_code, 8'h3c);
      wr(flas_pkg::OFF_AUDIO, 8'h00);
      chk(o_sink_code, 8'h11);
      // Measurement: a start at enable, its result one period later, then one per period.
      // The model code is 40h plus 13h per start; the source loop gave one start.
      wr(flas_pkg::OFF_TEST_SEL, 8'h1f);
      wait_pulse(1'b0);
      chk({7'h00, n == 1}, 8'h01);
      wait_pulse(1'b0);
      chk({7'h00, n == flas_pkg::CONV_CYCLES - 1}, 8'h01);
      rd(flas_pkg::OFF_TEST_RES);
      chk(d, 8'h66);
      // One falling edge went to the read.
      wait_pulse(1'b0);
      chk({7'h00, n == flas_pkg::CONV_CYCLES - 1}, 8'h01);
      rd(flas_pkg::OFF_TEST_RES);
      chk(d, 8'h79);
      // Measurement off and slow refresh: no pulse of either kind, result held.
      wr(flas_pkg::OFF_TEST_SEL, 8'h00);
      wr(flas_pkg::OFF_AUDIO, 8'h05);
      n = 0;
      repeat (13000)
      begin
         @(negedge i_clk);
         if (o_adc_start === 1'b1 || o_refresh === 1'b1)
            n++;
      end
      chk({7'h00, n == 0}, 8'h01);
      rd(flas_pkg::OFF_TEST_RES);
      chk(d, 8'h79);
      final_report();
   end
endmodule
`default_nettype wire
